// ===== rtl/omsc_pkg.sv
`default_nettype none

package omsc_pkg;

	// ------------------------------------------------------------
	// Register offsets (byte addresses are four times the index)
	// ------------------------------------------------------------
	localparam logic [7:0] IDX_SEL_PRIMARY = 8'h1C;
	localparam logic [7:0] IDX_RSVD_1D = 8'h1D;
	localparam logic [7:0] IDX_SEL_SECONDARY = 8'h1E;
	localparam logic [7:0] IDX_CONTROL = 8'h40;
	localparam logic [7:0] IDX_STATUS = 8'h41;
	localparam logic [7:0] RST_SEL_PRIMARY = 8'h58;
	localparam logic [7:0] RST_RSVD_1D = 8'h00;
	localparam logic [7:0] RST_SEL_SECONDARY = 8'h09;
	localparam logic [7:0] RST_CONTROL = 8'h00;

	// ------------------------------------------------------------
	// Field positions
	// ------------------------------------------------------------
	localparam int SEL_LSB = 5;
	localparam int CLK_CHOICE_BIT = 4;
	localparam int COMBINED_LSB = 2;
	localparam int CTRL_MANUAL_BIT = 0;
	localparam int CTRL_PIN_OVR_BIT = 1;

	// ------------------------------------------------------------
	// Select encodings
	// ------------------------------------------------------------
	localparam logic [2:0] P_MUTE = 3'h0;
	localparam logic [2:0] P_CLK10 = 3'h1;
	localparam logic [2:0] P_RAW = 3'h2;
	localparam logic [2:0] P_RETIMED = 3'h4;
	localparam logic [2:0] S_RAW = 3'h0;
	localparam logic [2:0] S_RETIMED = 3'h1;
	localparam logic [2:0] S_VCO = 3'h2;
	localparam logic [2:0] S_CLKSEL = 3'h5;
	localparam logic [2:0] S_MUTE = 3'h7;
	localparam logic [1:0] C_MUTE = 2'h0;
	localparam logic [1:0] C_CLOCK = 2'h1;
	localparam logic [1:0] C_RETIME = 2'h2;
	localparam logic [1:0] C_RAW = 2'h3;

	typedef enum logic [2:0] {
		OMSC_SRC_MUTE,
		OMSC_SRC_RAW,
		OMSC_SRC_RETIMED,
		OMSC_SRC_CLK10,
		OMSC_SRC_VCO,
		OMSC_SRC_DIV40_CLK
	} omsc_src_t;

	typedef struct packed {
		logic locked;
		logic above_3g;
	} omsc_cdr_t;

	typedef struct packed {
		omsc_src_t primary;
		omsc_src_t secondary;
	} omsc_route_t;

endpackage : omsc_pkg

`default_nettype wire

// ===== rtl/omsc_route.sv
`timescale 1ns/10ps
`default_nettype none

// Pure selection logic from settings and loop state to both output sources.
module omsc_route (
	// Settings
	input wire logic manual,
	input wire logic [2:0] primary_select_field,
	input wire logic [2:0] secondary_select_field,
	input wire logic clock_choice_bit,
	input wire logic [1:0] combined,
	// Loop state
	input wire omsc_pkg::omsc_cdr_t cdr,
	// Result
	output omsc_pkg::omsc_route_t route
);

	always_comb begin
		route.primary = omsc_pkg::OMSC_SRC_MUTE;
		route.secondary = omsc_pkg::OMSC_SRC_MUTE;
		if (manual) begin
			case (primary_select_field)
				omsc_pkg::P_CLK10: route.primary = omsc_pkg::OMSC_SRC_CLK10;
				omsc_pkg::P_RAW: route.primary = omsc_pkg::OMSC_SRC_RAW;
				omsc_pkg::P_RETIMED: route.primary = omsc_pkg::OMSC_SRC_RETIMED;
				default: route.primary = omsc_pkg::OMSC_SRC_MUTE;
			endcase
			case (secondary_select_field)
				omsc_pkg::S_RAW: route.secondary = omsc_pkg::OMSC_SRC_RAW;
				omsc_pkg::S_RETIMED: route.secondary = omsc_pkg::OMSC_SRC_RETIMED;
				omsc_pkg::S_VCO: route.secondary = omsc_pkg::OMSC_SRC_VCO;
				omsc_pkg::S_CLKSEL: route.secondary = clock_choice_bit ? omsc_pkg::OMSC_SRC_DIV40_CLK
					: omsc_pkg::OMSC_SRC_CLK10;
				default: route.secondary = omsc_pkg::OMSC_SRC_MUTE;
			endcase
		end else begin
			case (combined)
				omsc_pkg::C_MUTE: begin
					route.primary = omsc_pkg::OMSC_SRC_MUTE;
					route.secondary = omsc_pkg::OMSC_SRC_MUTE;
				end
				omsc_pkg::C_CLOCK: begin
					if (cdr.locked) begin
						route.primary = omsc_pkg::OMSC_SRC_RETIMED;
						route.secondary = cdr.above_3g ? omsc_pkg::OMSC_SRC_DIV40_CLK : omsc_pkg::OMSC_SRC_VCO;
					end else begin
						route.primary = omsc_pkg::OMSC_SRC_RAW;
						route.secondary = omsc_pkg::OMSC_SRC_MUTE;
					end
				end
				omsc_pkg::C_RETIME: begin
					route.primary = cdr.locked ? omsc_pkg::OMSC_SRC_RETIMED : omsc_pkg::OMSC_SRC_RAW;
					route.secondary = cdr.locked ? omsc_pkg::OMSC_SRC_RETIMED : omsc_pkg::OMSC_SRC_RAW;
				end
				default: begin
					route.primary = omsc_pkg::OMSC_SRC_RAW;
					route.secondary = omsc_pkg::OMSC_SRC_RAW;
				end
			endcase
		end
	end

endmodule : omsc_route
`default_nettype wire

// ===== rtl/omsc_sync.sv
`timescale 1ns/10ps
`default_nettype none

// Three-stage synchroniser; the output changes once stages two and three agree.
module omsc_sync (
	// Clock and reset
	input wire logic clock,
	input wire logic reset_n,
	// Data
	input wire logic d,
	output logic q
);

	logic s1_r;
	logic s2_r;
	logic s3_r;

	always_ff @(posedge clock or negedge reset_n) begin
		if (!reset_n) begin
			s1_r <= 1'b0;
			s2_r <= 1'b0;
			s3_r <= 1'b0;
			q <= 1'b0;
		end else begin
			s1_r <= d;
			s2_r <= s1_r;
			s3_r <= s2_r;
			if (s2_r == s3_r) begin
				q <= s3_r;
			end
		end
	end

endmodule : omsc_sync
`default_nettype wire

// ===== rtl/omsc_top.sv
`timescale 1ns/10ps
`default_nettype none

module omsc_top (
	// Clock and reset
	input wire logic clock,
	input wire logic reset_n,
	// AXI4-Lite write address
	input wire logic [31:0] s_axi_awaddr,
	input wire logic s_axi_awvalid,
	output logic s_axi_awready,
	// AXI4-Lite write data
	input wire logic [31:0] s_axi_wdata,
	input wire logic [3:0] s_axi_wstrb,
	input wire logic s_axi_wvalid,
	output logic s_axi_wready,
	// AXI4-Lite write response
	output logic [1:0] s_axi_bresp,
	output logic s_axi_bvalid,
	input wire logic s_axi_bready,
	// AXI4-Lite read address
	input wire logic [31:0] s_axi_araddr,
	input wire logic s_axi_arvalid,
	output logic s_axi_arready,
	// AXI4-Lite read data
	output logic [31:0] s_axi_rdata,
	output logic [1:0] s_axi_rresp,
	output logic s_axi_rvalid,
	input wire logic s_axi_rready,
	// Recovery loop and pin
	input wire logic cdr_locked,
	input wire logic cdr_above_3g,
	input wire logic [1:0] out_ctrl_pin,
	// Output selection
	output omsc_pkg::omsc_src_t primary_output,
	output omsc_pkg::omsc_src_t secondary_output
);

	// ------------------------------------------------------------
	// Input synchronisers
	// ------------------------------------------------------------
	logic [3:0] pin_raw;
	logic [3:0] pin_sync;
	assign pin_raw = {cdr_locked, cdr_above_3g, out_ctrl_pin};

	genvar gi;
	generate
		for (gi = 0; gi < 4; gi++) begin : g_sync
			omsc_sync u_sync (
				.clock(clock),
				.reset_n(reset_n),
				.d(pin_raw[gi]),
				.q(pin_sync[gi])
			);
		end
	endgenerate

	omsc_pkg::omsc_cdr_t cdr;
	assign cdr.locked = pin_sync[3];
	assign cdr.above_3g = pin_sync[2];

	// ------------------------------------------------------------
	// Register storage
	// ------------------------------------------------------------
	logic [7:0] sel_primary_r;
	logic [7:0] rsvd_1d_r;
	logic [7:0] sel_secondary_r;
	logic [7:0] control_r;
	logic manual;
	logic pin_override;
	logic [1:0] combined;
	omsc_pkg::omsc_route_t route;

	assign manual = control_r[omsc_pkg::CTRL_MANUAL_BIT];
	assign pin_override = control_r[omsc_pkg::CTRL_PIN_OVR_BIT];
	// field replaces pin only under override
	assign combined = pin_override ? sel_primary_r[omsc_pkg::COMBINED_LSB +: 2] : pin_sync[1:0];

	omsc_route u_route (
		.manual(manual),
		.primary_select_field(sel_primary_r[omsc_pkg::SEL_LSB +: 3]),
		.secondary_select_field(sel_secondary_r[omsc_pkg::SEL_LSB +: 3]),
		.clock_choice_bit(sel_primary_r[omsc_pkg::CLK_CHOICE_BIT]),
		.combined(combined),
		.cdr(cdr),
		.route(route)
	);

	// Applied code for read-back, in the manual select encoding.
	function automatic logic [2:0] prim_code(input omsc_pkg::omsc_src_t s);
		case (s)
			omsc_pkg::OMSC_SRC_CLK10: prim_code = omsc_pkg::P_CLK10;
			omsc_pkg::OMSC_SRC_RAW: prim_code = omsc_pkg::P_RAW;
			omsc_pkg::OMSC_SRC_RETIMED: prim_code = omsc_pkg::P_RETIMED;
			default: prim_code = omsc_pkg::P_MUTE;
		endcase
	endfunction : prim_code

	function automatic logic [2:0] sec_code(input omsc_pkg::omsc_src_t s);
		case (s)
			omsc_pkg::OMSC_SRC_RAW: sec_code = omsc_pkg::S_RAW;
			omsc_pkg::OMSC_SRC_RETIMED: sec_code = omsc_pkg::S_RETIMED;
			omsc_pkg::OMSC_SRC_VCO: sec_code = omsc_pkg::S_VCO;
			omsc_pkg::OMSC_SRC_CLK10: sec_code = omsc_pkg::S_CLKSEL;
			omsc_pkg::OMSC_SRC_DIV40_CLK: sec_code = omsc_pkg::S_CLKSEL;
			default: sec_code = omsc_pkg::S_MUTE;
		endcase
	endfunction : sec_code

	// ------------------------------------------------------------
	// Output registers
	// ------------------------------------------------------------
	always_ff @(posedge clock or negedge reset_n) begin
		if (!reset_n) begin
			primary_output <= omsc_pkg::OMSC_SRC_RAW;
			secondary_output <= omsc_pkg::OMSC_SRC_RAW;
		end else begin
			primary_output <= route.primary;
			secondary_output <= route.secondary;
		end
	end

	// ------------------------------------------------------------
	// AXI4-Lite write path
	// ------------------------------------------------------------
	logic aw_held_r;
	logic w_held_r;
	logic [7:0] aw_idx_r;
	logic [7:0] w_data_r;
	logic w_lane_r;
	logic do_write;
	logic [7:0] wr_idx;

	assign do_write = aw_held_r && w_held_r && !s_axi_bvalid;
	assign wr_idx = aw_idx_r;

	always_ff @(posedge clock or negedge reset_n) begin
		if (!reset_n) begin
			aw_held_r <= 1'b0;
			aw_idx_r <= 8'h00;
			s_axi_awready <= 1'b0;
		end else begin
			s_axi_awready <= !aw_held_r && !s_axi_awready && s_axi_awvalid;
			if (s_axi_awvalid && s_axi_awready) begin
				aw_held_r <= 1'b1;
				aw_idx_r <= s_axi_awaddr[9:2];
			end else if (do_write) begin
				aw_held_r <= 1'b0;
			end
		end
	end

	always_ff @(posedge clock or negedge reset_n) begin
		if (!reset_n) begin
			w_held_r <= 1'b0;
			w_data_r <= 8'h00;
			w_lane_r <= 1'b0;
			s_axi_wready <= 1'b0;
		end else begin
			s_axi_wready <= !w_held_r && !s_axi_wready && s_axi_wvalid;
			if (s_axi_wvalid && s_axi_wready) begin
				w_held_r <= 1'b1;
				w_data_r <= s_axi_wdata[7:0];
				w_lane_r <= s_axi_wstrb[0];
			end else if (do_write) begin
				w_held_r <= 1'b0;
			end
		end
	end

	logic wr_hit;
	assign wr_hit = (wr_idx == omsc_pkg::IDX_SEL_PRIMARY) || (wr_idx == omsc_pkg::IDX_RSVD_1D)
		|| (wr_idx == omsc_pkg::IDX_SEL_SECONDARY) || (wr_idx == omsc_pkg::IDX_CONTROL)
		|| (wr_idx == omsc_pkg::IDX_STATUS);

	always_ff @(posedge clock or negedge reset_n) begin
		if (!reset_n) begin
			s_axi_bvalid <= 1'b0;
			s_axi_bresp <= 2'h0;
		end else if (do_write) begin
			s_axi_bvalid <= 1'b1;
			s_axi_bresp <= wr_hit ? 2'h0 : 2'h2;
		end else if (s_axi_bready) begin
			s_axi_bvalid <= 1'b0;
		end
	end

	// ------------------------------------------------------------
	// Register writes
	// ------------------------------------------------------------
	always_ff @(posedge clock or negedge reset_n) begin
		if (!reset_n) begin
			sel_primary_r <= omsc_pkg::RST_SEL_PRIMARY;
			rsvd_1d_r <= omsc_pkg::RST_RSVD_1D;
			sel_secondary_r <= omsc_pkg::RST_SEL_SECONDARY;
			control_r <= omsc_pkg::RST_CONTROL;
		end else if (do_write && w_lane_r) begin
			case (wr_idx)
				omsc_pkg::IDX_SEL_PRIMARY: sel_primary_r <= w_data_r;
				omsc_pkg::IDX_RSVD_1D: rsvd_1d_r <= w_data_r;
				omsc_pkg::IDX_SEL_SECONDARY: sel_secondary_r <= w_data_r;
				omsc_pkg::IDX_CONTROL: control_r <= {6'h00, w_data_r[1:0]};
				default: ;
			endcase
		end
	end

	// ------------------------------------------------------------
	// AXI4-Lite read path
	// ------------------------------------------------------------
	logic [7:0] rd_idx;
	logic [7:0] rd_val;
	logic rd_hit;
	assign rd_idx = s_axi_araddr[9:2];

	always_comb begin
		rd_val = 8'h00;
		rd_hit = 1'b1;
		case (rd_idx)
			omsc_pkg::IDX_SEL_PRIMARY: rd_val = manual ? sel_primary_r
				: {prim_code(primary_output), sel_primary_r[4:0]};
			omsc_pkg::IDX_RSVD_1D: rd_val = rsvd_1d_r;
			omsc_pkg::IDX_SEL_SECONDARY: rd_val = manual ? sel_secondary_r
				: {sec_code(secondary_output), sel_secondary_r[4:0]};
			omsc_pkg::IDX_CONTROL: rd_val = control_r;
			omsc_pkg::IDX_STATUS: rd_val = {4'h0, cdr.locked, cdr.above_3g, combined};
			default: rd_hit = 1'b0;
		endcase
	end

	always_ff @(posedge clock or negedge reset_n) begin
		if (!reset_n) begin
			s_axi_arready <= 1'b0;
			s_axi_rvalid <= 1'b0;
			s_axi_rdata <= 32'h0000_0000;
			s_axi_rresp <= 2'h0;
		end else begin
			s_axi_arready <= !s_axi_rvalid && !s_axi_arready && s_axi_arvalid;
			if (s_axi_arvalid && s_axi_arready) begin
				s_axi_rvalid <= 1'b1;
				s_axi_rdata <= {24'h00_0000, rd_val};
				s_axi_rresp <= rd_hit ? 2'h0 : 2'h2;
			end else if (s_axi_rready) begin
				s_axi_rvalid <= 1'b0;
			end
		end
	end

	// ------------------------------------------------------------
	// Assertions
	// ------------------------------------------------------------
	AST_COMB_RAW: assert property (@(posedge clock) disable iff (!reset_n)
		(!manual && combined == omsc_pkg::C_RAW) |=> primary_output == omsc_pkg::OMSC_SRC_RAW
		&& secondary_output == omsc_pkg::OMSC_SRC_RAW)
		else $error("combined 11 must give raw on both");
	AST_COMB_MUTE: assert property (@(posedge clock) disable iff (!reset_n)
		(!manual && combined == omsc_pkg::C_MUTE) |=> primary_output == omsc_pkg::OMSC_SRC_MUTE
		&& secondary_output == omsc_pkg::OMSC_SRC_MUTE)
		else $error("combined 00 must mute both");
	AST_PIN_USED: assert property (@(posedge clock) disable iff (!reset_n)
		(!manual && !pin_override && pin_sync[1:0] == omsc_pkg::C_RAW)
		|=> primary_output == omsc_pkg::OMSC_SRC_RAW && secondary_output == omsc_pkg::OMSC_SRC_RAW)
		else $error("pin must drive the selection without override");
	AST_CLK_LOCKED: assert property (@(posedge clock) disable iff (!reset_n)
		(!manual && combined == omsc_pkg::C_CLOCK && cdr.locked && cdr.above_3g)
		|=> secondary_output == omsc_pkg::OMSC_SRC_DIV40_CLK && primary_output == omsc_pkg::OMSC_SRC_RETIMED)
		else $error("combined 01 above 3G must give div40");
	AST_CLK_UNLOCKED: assert property (@(posedge clock) disable iff (!reset_n)
		(!manual && combined == omsc_pkg::C_CLOCK && !cdr.locked)
		|=> secondary_output == omsc_pkg::OMSC_SRC_MUTE && primary_output == omsc_pkg::OMSC_SRC_RAW)
		else $error("combined 01 unlocked wrong");
	AST_RETIME: assert property (@(posedge clock) disable iff (!reset_n)
		(!manual && combined == omsc_pkg::C_RETIME && cdr.locked) |=> secondary_output == omsc_pkg::OMSC_SRC_RETIMED)
		else $error("combined 10 locked must retime");
	AST_MAN_PRIM: assert property (@(posedge clock) disable iff (!reset_n)
		(manual && sel_primary_r[7:5] == omsc_pkg::P_CLK10) |=> primary_output == omsc_pkg::OMSC_SRC_CLK10)
		else $error("manual primary 001 must be 10MHz");
	AST_MAN_CHOICE: assert property (@(posedge clock) disable iff (!reset_n)
		(manual && sel_secondary_r[7:5] == omsc_pkg::S_CLKSEL && sel_primary_r[4])
		|=> secondary_output == omsc_pkg::OMSC_SRC_DIV40_CLK)
		else $error("clock choice 1 must give div40");
	AST_MAN_SEC_MUTE: assert property (@(posedge clock) disable iff (!reset_n)
		(manual && sel_secondary_r[7:5] == omsc_pkg::S_MUTE) |=> secondary_output == omsc_pkg::OMSC_SRC_MUTE)
		else $error("manual secondary 111 must mute");
	AST_READBACK: assert property (@(posedge clock) disable iff (!reset_n)
		(s_axi_arvalid && s_axi_arready && !manual && rd_idx == omsc_pkg::IDX_SEL_PRIMARY)
		|=> s_axi_rdata[7:5] == prim_code($past(primary_output)))
		else $error("primary read-back must show applied selection");
	AST_READBACK2: assert property (@(posedge clock) disable iff (!reset_n)
		(s_axi_arvalid && s_axi_arready && !manual && rd_idx == omsc_pkg::IDX_SEL_SECONDARY)
		|=> s_axi_rdata[7:5] == sec_code($past(secondary_output)))
		else $error("secondary read-back must show applied selection");
	AST_RESET_COMB: assert property (@(posedge clock) disable iff (!reset_n)
		$rose(reset_n) |-> sel_primary_r[3:2] == omsc_pkg::C_RETIME)
		else $error("combined field must reset to 10");
	COV_MANUAL: cover property (@(posedge clock) disable iff (!reset_n) manual && sel_primary_r[7:5] == omsc_pkg::P_RETIMED);
	COV_CLOCK_MODE: cover property (@(posedge clock) disable iff (!reset_n) !manual && combined == omsc_pkg::C_CLOCK);
	COV_WRITE: cover property (@(posedge clock) disable iff (!reset_n) s_axi_bvalid && s_axi_bready);

endmodule : omsc_top
`default_nettype wire

// ===== tb/omsc_bench.sv
`timescale 1ns/10ps
`default_nettype none

module output_mux_select_control_bench;

	// ------------------------------------------------------------
	// Signals
	// ------------------------------------------------------------
	typedef struct packed {
		logic [1:0] kind;
		logic [33:0] val;
	} omsc_note_t;

	localparam logic [31:0] A_PRI = 32'h00000070;
	localparam logic [31:0] A_RSV = 32'h00000074;
	localparam logic [31:0] A_SEC = 32'h00000078;
	localparam logic [31:0] A_CTL = 32'h00000100;
	localparam logic [31:0] A_STS = 32'h00000104;
	localparam logic [31:0] A_BAD = 32'h00000000;
	localparam int LIMIT = 20000;

	logic clock, reset_n;
	logic [31:0] s_axi_awaddr, s_axi_wdata, s_axi_araddr, s_axi_rdata;
	logic s_axi_awvalid, s_axi_awready, s_axi_wvalid, s_axi_wready, s_axi_bvalid, s_axi_bready;
	logic s_axi_arvalid, s_axi_arready, s_axi_rvalid, s_axi_rready;
	logic [3:0] s_axi_wstrb;
	logic [1:0] s_axi_bresp, s_axi_rresp, out_ctrl_pin;
	logic cdr_locked, cdr_above_3g, out_chk;
	omsc_pkg::omsc_src_t primary_output, secondary_output;
	omsc_note_t notes[$];
	int err_total, check_count, cyc;

	omsc_top omsc_top_i (.clock(clock), .reset_n(reset_n),
		.s_axi_awaddr(s_axi_awaddr), .s_axi_awvalid(s_axi_awvalid), .s_axi_awready(s_axi_awready),
		.s_axi_wdata(s_axi_wdata), .s_axi_wstrb(s_axi_wstrb), .s_axi_wvalid(s_axi_wvalid),
		.s_axi_wready(s_axi_wready), .s_axi_bresp(s_axi_bresp), .s_axi_bvalid(s_axi_bvalid),
		.s_axi_bready(s_axi_bready), .s_axi_araddr(s_axi_araddr), .s_axi_arvalid(s_axi_arvalid),
		.s_axi_arready(s_axi_arready), .s_axi_rdata(s_axi_rdata), .s_axi_rresp(s_axi_rresp),
		.s_axi_rvalid(s_axi_rvalid), .s_axi_rready(s_axi_rready), .cdr_locked(cdr_locked),
		.cdr_above_3g(cdr_above_3g), .out_ctrl_pin(out_ctrl_pin),
		.primary_output(primary_output), .secondary_output(secondary_output));

	initial begin
		clock = 1'b0;
		forever #10 clock = ~clock;
	end

	// ------------------------------------------------------------
	// Verdict and watchdog
	// ------------------------------------------------------------
	task automatic results();
		$display("checks %0d mismatches %0d", check_count, err_total);
		if (err_total == 0 && check_count > 0) begin
			$display("Simulation passed");
		end else begin
			$display("Simulation failed");
		end
		$finish;
	endtask : results

	initial begin
		cyc = 0;
		forever begin
			@(posedge clock);
			cyc++;
			if (cyc == LIMIT) begin
				$display("[ERR] %0t watchdog expired", $time);
				err_total++;
				results();
			end
		end
	end

	// ------------------------------------------------------------
	// Monitor: each result is compared with the oldest note
	// ------------------------------------------------------------
	task automatic take(input logic [1:0] k, input logic [33:0] v);
		omsc_note_t n;
		check_count++;
		if (notes.size() == 0) begin
			$display("[ERR] %0t result with no expectation", $time);
			err_total++;
		end else begin
			n = notes.pop_front();
			if (n.kind !== k || n.val !== v) begin
				$display("[ERR] %0t kind %0d got %h expected %h", $time, k, v, n.val);
				err_total++;
			end
		end
	endtask : take

	always @(posedge clock) begin
		if (s_axi_bvalid && s_axi_bready) take(2'h0, {32'h00000000, s_axi_bresp});
		if (s_axi_rvalid && s_axi_rready) take(2'h1, {s_axi_rresp, s_axi_rdata});
		if (out_chk) take(2'h2, {28'h0000000, primary_output, secondary_output});
	end

	// ------------------------------------------------------------
	// Drivers
	// ------------------------------------------------------------
	task automatic axi_wr(input logic [31:0] a, input logic [7:0] d, input logic [1:0] er);
		notes.push_back({2'h0, 32'h00000000, er});
		@(posedge clock);
		s_axi_awaddr <= a;
		s_axi_wdata <= {24'h000000, d};
		s_axi_awvalid <= 1'b1;
		s_axi_wvalid <= 1'b1;
		s_axi_bready <= 1'b1;
		forever begin
			@(posedge clock);
			if (s_axi_awready) s_axi_awvalid <= 1'b0;
			if (s_axi_wready) s_axi_wvalid <= 1'b0;
			if (s_axi_bvalid) break;
		end
		s_axi_bready <= 1'b0;
	endtask : axi_wr

	task automatic axi_rd(input logic [31:0] a, input logic [7:0] ed, input logic [1:0] er);
		notes.push_back({2'h1, er, 24'h000000, ed});
		@(posedge clock);
		s_axi_araddr <= a;
		s_axi_arvalid <= 1'b1;
		s_axi_rready <= 1'b1;
		forever begin
			@(posedge clock);
			if (s_axi_arready) s_axi_arvalid <= 1'b0;
			if (s_axi_rvalid) break;
		end
		s_axi_rready <= 1'b0;
	endtask : axi_rd

	task automatic chk_out(input logic [2:0] p, input logic [2:0] s);
		notes.push_back({2'h2, 28'h0000000, p, s});
		out_chk <= 1'b1;
		@(posedge clock);
		out_chk <= 1'b0;
		@(posedge clock);
	endtask : chk_out

	// ------------------------------------------------------------
	// Expectations
	// ------------------------------------------------------------
	function automatic logic [5:0] exp_comb(input logic [1:0] c, input logic lk, input logic hi);
		case (c)
			2'h0: return {omsc_pkg::OMSC_SRC_MUTE, omsc_pkg::OMSC_SRC_MUTE};
			2'h1: return lk ? {omsc_pkg::OMSC_SRC_RETIMED, hi ? omsc_pkg::OMSC_SRC_DIV40_CLK : omsc_pkg::OMSC_SRC_VCO}
				: {omsc_pkg::OMSC_SRC_RAW, omsc_pkg::OMSC_SRC_MUTE};
			2'h2: return lk ? {omsc_pkg::OMSC_SRC_RETIMED, omsc_pkg::OMSC_SRC_RETIMED}
				: {omsc_pkg::OMSC_SRC_RAW, omsc_pkg::OMSC_SRC_RAW};
			default: return {omsc_pkg::OMSC_SRC_RAW, omsc_pkg::OMSC_SRC_RAW};
		endcase
	endfunction : exp_comb

	function automatic logic [2:0] pri_code(input logic [2:0] src);
		case (src)
			3'h1: return 3'h2;
			3'h2: return 3'h4;
			3'h3: return 3'h1;
			default: return 3'h0;
		endcase
	endfunction : pri_code

	function automatic logic [2:0] sec_code(input logic [2:0] src);
		case (src)
			3'h1: return 3'h0;
			3'h2: return 3'h1;
			3'h4: return 3'h2;
			3'h3, 3'h5: return 3'h5;
			default: return 3'h7;
		endcase
	endfunction : sec_code

	// Manual codes: any code outside the listed ones must leave the output muted.
	function automatic logic [2:0] pri_src(input logic [2:0] code);
		case (code)
			3'h1: return 3'h3;
			3'h2: return 3'h1;
			3'h4: return 3'h2;
			default: return 3'h0;
		endcase
	endfunction : pri_src

	function automatic logic [2:0] sec_src(input logic [2:0] code, input logic k);
		case (code)
			3'h0: return 3'h1;
			3'h1: return 3'h2;
			3'h2: return 3'h4;
			3'h5: return k ? 3'h5 : 3'h3;
			default: return 3'h0;
		endcase
	endfunction : sec_src

	// ------------------------------------------------------------
	// Main sequence
	// ------------------------------------------------------------
	initial begin
		logic [1:0] c;
		logic lk, hi;
		logic [5:0] e;
		logic [31:0] r;
		logic [2:0] j;
		logic [7:0] pv, sv;
		reset_n = 1'b0;
		{s_axi_awaddr, s_axi_wdata, s_axi_araddr} = '0;
		{s_axi_awvalid, s_axi_wvalid, s_axi_bready, s_axi_arvalid, s_axi_rready, out_chk} = '0;
		s_axi_wstrb = 4'hF;
		out_ctrl_pin = 2'h2;
		cdr_locked = 1'b0;
		cdr_above_3g = 1'b0;
		err_total = 0;
		check_count = 0;
		void'($urandom(25950));
		repeat (20) @(posedge clock);
		reset_n <= 1'b1;
		repeat (8) @(posedge clock);
		chk_out(3'h1, 3'h1);
		axi_rd(A_PRI, 8'h58, 2'h0);
		axi_rd(A_SEC, 8'h09, 2'h0);
		axi_rd(A_RSV, 8'h00, 2'h0);
		axi_rd(A_CTL, 8'h00, 2'h0);
		axi_rd(A_BAD, 8'h00, 2'h2);
		axi_wr(A_BAD, 8'hFF, 2'h2);
		// A write with the low byte lane off is answered but stores nothing.
		s_axi_wstrb <= 4'h0;
		axi_wr(A_RSV, 8'h5A, 2'h0);
		s_axi_wstrb <= 4'hF;
		axi_rd(A_RSV, 8'h00, 2'h0);
		axi_wr(A_RSV, 8'hA5, 2'h0);
		axi_rd(A_RSV, 8'hA5, 2'h0);
		cdr_locked <= 1'b1;
		axi_wr(A_CTL, 8'h02, 2'h0);
		repeat (8) @(posedge clock);
		chk_out(3'h2, 3'h2);
		$display("test reset done");
		for (int pass = 0; pass < 2; pass++) begin
			for (int i = 0; i < 16; i++) begin
				c = i[1:0];
				lk = i[2];
				hi = i[3];
				cdr_locked <= lk;
				cdr_above_3g <= hi;
				out_ctrl_pin <= (pass == 0) ? 2'($urandom) : c;
				axi_wr(A_CTL, (pass == 0) ? 8'h02 : 8'h00, 2'h0);
				axi_wr(A_PRI, {4'h0, (pass == 0) ? c : ~c, 2'h0}, 2'h0);
				repeat (8) @(posedge clock);
				e = exp_comb(c, lk, hi);
				chk_out(e[5:3], e[2:0]);
				axi_rd(A_PRI, {pri_code(e[5:3]), 1'b0, (pass == 0) ? c : ~c, 2'h0}, 2'h0);
				axi_rd(A_SEC, {sec_code(e[2:0]), 5'h09}, 2'h0);
				axi_rd(A_STS, {4'h0, lk, hi, c}, 2'h0);
			end
		end
		$display("test combined done");
		axi_wr(A_CTL, 8'h01, 2'h0);
		for (int i = 0; i < 16; i++) begin
			j = i[3:1];
			r = $urandom;
			cdr_locked <= r[9];
			cdr_above_3g <= r[10];
			pv = {j, i[0], r[3:0]};
			sv = {3'h7 - j, r[8:4]};
			axi_wr(A_PRI, pv, 2'h0);
			axi_wr(A_SEC, sv, 2'h0);
			repeat (3) @(posedge clock);
			chk_out(pri_src(j), sec_src(3'h7 - j, i[0]));
			axi_rd(A_PRI, pv, 2'h0);
			axi_rd(A_SEC, sv, 2'h0);
		end
		$display("test manual done");
		repeat (4) @(posedge clock);
		if (notes.size() != 0) begin
			$display("[ERR] %0t expectations left unmatched", $time);
			err_total++;
		end
		results();
	end

endmodule : output_mux_select_control_bench

`default_nettype wire
